// ### hdl/uart_pkg.sv
package uart_pkg;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] DATA_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] MASK_ADDR = 8'h0c;
    localparam logic [7:0] BAUD_ADDR = 8'h10;
    // Control fields
    localparam int CTRL_WLS = 7;
    localparam int CTRL_MCE = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_N9 = 2;
    localparam int CTRL_TXD = 1;
    localparam int CTRL_RXD = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Status / mask fields
    localparam int ST_TXD = 0;
    localparam int ST_RXD = 1;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // Baud timebase: last oversample tick index (16 ticks per bit), mid-bit sample index and default divider; frame width and response codes
    localparam logic [3:0] OVERSAMPLE = 4'hf;
    localparam logic [3:0] MID_SAMPLE = 4'h7;
    localparam logic [15:0] BAUD_RESET = 16'h0001;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic stopBit;
    } rx_frame_t;
endpackage

// ### hdl/uart_rx.sv
`timescale 1ns/1ps
module uart_rx
    import uart_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rstSync_n,
    // Timebase and line
    input wire logic tick,
    input wire logic enable,
    input wire logic serialIn,
    // Frame out
    output rx_frame_t frame,
    output logic frameValid
);
    typedef enum {IDLE, START, DATA, STOP} rx_state_t;
    rx_state_t state_q;
    logic [3:0] phase_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic prevIn_q;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            prevIn_q <= 1'b1;
        end else begin
            prevIn_q <= serialIn;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q <= IDLE;
            phase_q <= 4'h0;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            frame <= '0;
            frameValid <= 1'b0;
        end else begin
            frameValid <= 1'b0;
            unique case (state_q)
                IDLE: begin
                    // Falling edge starts a frame
                    if (enable && prevIn_q && !serialIn) begin
                        state_q <= START;
                        phase_q <= 4'h0;
                    end
                end
                START: begin
                    if (tick) begin
                        phase_q <= phase_q + 4'h1;
                        if (phase_q == MID_SAMPLE) begin
                            phase_q <= 4'h0;
                            bitCnt_q <= 4'h0;
                            state_q <= serialIn ? IDLE : DATA;
                        end
                    end
                end
                DATA: begin
                    if (tick) begin
                        phase_q <= phase_q + 4'h1;
                        if (phase_q == OVERSAMPLE) begin
                            // LSB first, sampled mid bit
                            shift_q <= {serialIn, shift_q[7:1]};
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == DATA_BITS - 4'h1) begin
                                state_q <= STOP;
                            end
                        end
                    end
                end
                STOP: begin
                    if (tick) begin
                        phase_q <= phase_q + 4'h1;
                        if (phase_q == OVERSAMPLE) begin
                            frame <= '{data: shift_q, stopBit: serialIn};
                            frameValid <= 1'b1;
                            state_q <= IDLE;
                        end
                    end
                end
            endcase
        end
    end

    chk_rx_start_idle: assert property (@(posedge clk) disable iff
        (!rstSync_n) (state_q == IDLE && !enable) |=> state_q == IDLE)
        else $error("receiver left idle while disabled");
endmodule

// ### hdl/uart_eight_bit.sv
`timescale 1ns/1ps
module uart_eight_bit
    import uart_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial line
    input wire logic serialInPin,
    output logic serialOutPin,
    // Interrupt
    output logic irq
);
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    logic [7:0] ctrl_q;
    logic [7:0] rxBuf_q;
    logic [15:0] baud_q;
    logic [15:0] baudCnt_q;
    logic tick;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic txDoneSet;
    logic rxDoneSet;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic awHave_q;
    logic wHave_q;
    logic doWrite;
    logic doRead;
    logic txStart;
    rx_frame_t rxFrame;
    logic rxValid;
    logic loadOk;

    // Baud oversample timebase
    assign tick = (baudCnt_q == 16'h0000);
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            baudCnt_q <= 16'h0000;
        end else begin
            baudCnt_q <= tick ? baud_q : baudCnt_q - 16'h0001;
        end
    end

    // Write channel capture, either order
    assign doWrite = awHave_q && wHave_q && !bvalid;
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            awready <= !awHave_q && !(awvalid && awready);
            wready <= !wHave_q && !(wvalid && wready);
            if (awvalid && awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHave_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
                bvalid <= 1'b1;
                bresp <= (awAddr_q == CTRL_ADDR || awAddr_q == DATA_ADDR ||
                    awAddr_q == MASK_ADDR || awAddr_q == BAUD_ADDR)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Buffer write launches a frame
    assign txStart = doWrite && awAddr_q == DATA_ADDR && wStrb_q[0];

    // Control register: software writes; hardware sets done flags
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            ctrl_q <= CTRL_RESET;
            mask_q <= MASK_RESET;
            baud_q <= BAUD_RESET;
        end else begin
            if (doWrite && awAddr_q == CTRL_ADDR && wStrb_q[0]) begin
                // Word-length select held in control
                ctrl_q <= wData_q[7:0];
            end
            if (doWrite && awAddr_q == MASK_ADDR && wStrb_q[0]) begin
                mask_q <= wData_q[1:0];
            end
            if (doWrite && awAddr_q == BAUD_ADDR) begin
                if (wStrb_q[0]) baud_q[7:0] <= wData_q[7:0];
                if (wStrb_q[1]) baud_q[15:8] <= wData_q[15:8];
            end
            // Set wins over a same-cycle software clear
            if (txDoneSet) begin
                ctrl_q[CTRL_TXD] <= 1'b1;
            end
            if (rxDoneSet) begin
                ctrl_q[CTRL_RXD] <= 1'b1;
                ctrl_q[CTRL_N9] <= rxFrame.stopBit;
            end
        end
    end

    // Load gate: done clear and, under check, stop high
    assign loadOk = rxValid && !ctrl_q[CTRL_RXD] &&
        (!ctrl_q[CTRL_MCE] || rxFrame.stopBit);
    assign rxDoneSet = loadOk;

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            rxBuf_q <= 8'h00;
        end else if (loadOk) begin
            // Otherwise held: first byte kept on overrun
            rxBuf_q <= rxFrame.data;
        end
    end

    // Transmitter, independent of receiver
    typedef enum {T_IDLE, T_START, T_DATA, T_STOP} tx_state_t;
    tx_state_t txState_q;
    logic [3:0] txPhase_q;
    logic [3:0] txBit_q;
    logic [7:0] txShift_q;
    assign txDoneSet = txState_q == T_DATA && tick &&
        txPhase_q == OVERSAMPLE && txBit_q == DATA_BITS - 4'h1;
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            txState_q <= T_IDLE;
            txPhase_q <= 4'h0;
            txBit_q <= 4'h0;
            txShift_q <= 8'h00;
            serialOutPin <= 1'b1;
        end else begin
            unique case (txState_q)
                T_IDLE: begin
                    if (txStart) begin
                        txShift_q <= wData_q[7:0];
                        txState_q <= T_START;
                        txPhase_q <= 4'h0;
                        serialOutPin <= 1'b0;
                    end
                end
                T_START, T_DATA, T_STOP: begin
                    if (tick) begin
                        txPhase_q <= txPhase_q + 4'h1;
                        if (txPhase_q == OVERSAMPLE) begin
                            unique case (txState_q)
                                T_START: begin
                                    // LSB first
                                    serialOutPin <= txShift_q[0];
                                    txBit_q <= 4'h0;
                                    txState_q <= T_DATA;
                                end
                                T_DATA: begin
                                    txBit_q <= txBit_q + 4'h1;
                                    if (txBit_q == DATA_BITS - 4'h1) begin
                                        serialOutPin <= 1'b1;
                                        txState_q <= T_STOP;
                                    end else begin
                                        serialOutPin <= txShift_q[1];
                                        txShift_q <= txShift_q >> 1;
                                    end
                                end
                                default: begin
                                    txState_q <= T_IDLE;
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    uart_rx rxUnit (
        .clk(clk),
        .rstSync_n(rstSync_q),
        .tick(tick),
        .enable(ctrl_q[CTRL_REN]),
        .serialIn(serialInPin),
        .frame(rxFrame),
        .frameValid(rxValid)
    );

    // Sticky interrupt status, cleared by reading it
    assign doRead = arvalid && arready;
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= (doRead && araddr == STAT_ADDR) ? 2'h0 : stat_q;
            if (txDoneSet) stat_q[ST_TXD] <= 1'b1;
            if (rxDoneSet) stat_q[ST_RXD] <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            arready <= !rvalid && !doRead;
            if (doRead) begin
                rvalid <= 1'b1;
                rresp <= RESP_OKAY;
                unique case (araddr)
                    CTRL_ADDR: rdata <= {24'h0, ctrl_q};
                    DATA_ADDR: rdata <= {24'h0, rxBuf_q};
                    STAT_ADDR: rdata <= {30'h0, stat_q};
                    MASK_ADDR: rdata <= {30'h0, mask_q};
                    BAUD_ADDR: rdata <= {16'h0, baud_q};
                    default: begin
                        rdata <= 32'h0;
                        rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    chk_load_sets_done: assert property (@(posedge clk) disable iff
        (!rstSync_q) loadOk |=> ctrl_q[CTRL_RXD])
        else $error("receive done not set after load");
    chk_load_buffer: assert property (@(posedge clk) disable iff
        (!rstSync_q) loadOk |=> rxBuf_q == $past(rxFrame.data))
        else $error("receive buffer missed the byte");
    chk_overrun_hold: assert property (@(posedge clk) disable iff
        (!rstSync_q) (rxValid && ctrl_q[CTRL_RXD]) |=> $stable(rxBuf_q))
        else $error("buffer changed on overrun");
    chk_mce_reject: assert property (@(posedge clk) disable iff
        (!rstSync_q) (rxValid && ctrl_q[CTRL_MCE] && !rxFrame.stopBit
        && !ctrl_q[CTRL_RXD] && !(doWrite && awAddr_q == CTRL_ADDR))
        |=> !ctrl_q[CTRL_RXD])
        else $error("bad stop bit loaded under check");
    chk_tx_done_stop: assert property (@(posedge clk) disable iff
        (!rstSync_q) txDoneSet |=> serialOutPin && ctrl_q[CTRL_TXD])
        else $error("transmit done not at stop start");
    chk_tx_start_bit: assert property (@(posedge clk) disable iff
        (!rstSync_q) (txStart && txState_q == T_IDLE) |=> !serialOutPin)
        else $error("no start bit after buffer write");
    chk_irq_follows: assert property (@(posedge clk) disable iff
        (!rstSync_q) (|(stat_q & mask_q)) |=> irq)
        else $error("interrupt not raised");
    chk_fail_no_change: assert property (@(posedge clk) disable iff
        (!rstSync_q) (!loadOk && !(doWrite && awAddr_q == CTRL_ADDR))
        |=> $stable(rxBuf_q) && $stable(ctrl_q[CTRL_N9]))
        else $error("state changed without load");
    cov_tx_done: cover property (@(posedge clk) txDoneSet);
    cov_rx_load: cover property (@(posedge clk) loadOk);
    cov_overrun: cover property (@(posedge clk) rxValid && ctrl_q[CTRL_RXD]);
    cov_duplex: cover property (@(posedge clk)
        txState_q == T_DATA && rxValid);
endmodule

// ### test/serial_peer.sv
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CLKS = 16
) (
    // System
    input wire logic clk,
    // Line
    input wire logic lineIn,
    output logic lineOut
);
    int cyc = 0;
    int startAt = 0;
    int rxCount = 0;
    logic [7:0] rxByte = 8'h00;
    logic rxStop = 1'b1;

    initial lineOut = 1'b1;

    always @(posedge clk) cyc <= cyc + 1;

    // Start low, data LSB first, stop, one idle bit time
    task automatic send(input logic [7:0] b, input logic stopBit);
        @(posedge clk);
        lineOut <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            lineOut <= b[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        lineOut <= stopBit;
        repeat (BIT_CLKS) @(posedge clk);
        lineOut <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask

    // Receiver samples each bit near its middle
    initial begin
        forever begin
            @(posedge clk);
            if (lineIn === 1'b0) begin
                startAt = cyc;
                repeat (BIT_CLKS / 2) @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CLKS) @(posedge clk);
                    rxByte[i] = lineIn;
                end
                repeat (BIT_CLKS) @(posedge clk);
                rxStop = lineIn;
                rxCount++;
                for (int k = 0; k < 4 * BIT_CLKS; k++) begin
                    if (lineIn === 1'b1) break;
                    @(posedge clk);
                end
            end
        end
    end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench
    import uart_pkg::*;
;
    localparam int B = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, serialOutPin;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    wire logic serialInPin;
    int mismatches = 0;
    int samplesChecked = 0;
    int seed = 91687;
    logic [7:0] expData;

    always #2 clk = ~clk;

    uart_eight_bit u_uart_eight_bit (.clk(clk), .rst_n(rst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .serialInPin(serialInPin), .serialOutPin(serialOutPin), .irq(irq));
    serial_peer #(.BIT_CLKS(B)) u_peer (.clk(clk),
        .lineIn(serialOutPin), .lineOut(serialInPin));

    task summarize;
        $display("checks %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task bail;
        mismatches++;
        $display("wait limit reached");
        summarize();
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 300);
        if (bvalid !== 1'b1) bail();
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 300);
        if (rvalid !== 1'b1) bail();
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
                         input string what);
        axiRead(a);
        check(rd, e, what);
    endtask

    task automatic waitPeer(input int cnt);
        int n;
        n = 0;
        while (u_peer.rxCount == cnt && n < 40 * B) begin
            @(posedge clk);
            n++;
        end
        if (u_peer.rxCount == cnt) bail();
        repeat (B + 4) @(posedge clk);
    endtask

    // Control value after a receive load
    function automatic logic [31:0] loadedCtrl(input logic mce,
                                               input logic stopBit);
        return {26'h0, mce, 1'b1, 1'b0, stopBit, 1'b0, 1'b1};
    endfunction

    task automatic txOne(input logic [7:0] b);
        int cnt;
        int n;
        cnt = u_peer.rxCount;
        axiWrite(DATA_ADDR, {24'h0, b});
        n = 0;
        while (irq !== 1'b1 && n < 20 * B) begin
            @(posedge clk);
            n++;
        end
        n = u_peer.cyc - u_peer.startAt;
        check(n >= 9 * B && n <= 9 * B + 4, 1, "txDoneTime");
        check(irq, 1, "irqTx");
        waitPeer(cnt);
        check(u_peer.rxByte, b, "txByte");
        check(u_peer.rxStop, 1, "txStop");
    endtask

    task automatic rxOne(input logic mce, input logic stopBit,
                         input logic load);
        logic [7:0] b;
        b = 8'($random(seed));
        u_peer.send(b, stopBit);
        repeat (4) @(posedge clk);
        check(irq, load, "irqRx");
        if (load) expData = b;
        rdChk(STAT_ADDR, {30'h0, load, 1'b0}, "rxStat");
        rdChk(DATA_ADDR, {24'h0, expData}, "rxData");
        if (load) begin
            rdChk(CTRL_ADDR, loadedCtrl(mce, stopBit), "ctrl");
        end
        $display("receive test done");
    endtask

    initial begin
        logic [7:0] tb;
        logic [7:0] rb;
        int cnt;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        check(irq, 0, "irqReset");
        rdChk(CTRL_ADDR, 32'h0, "ctrlReset");
        rdChk(MASK_ADDR, 32'h0, "maskReset");
        rdChk(BAUD_ADDR, 32'h1, "baudReset");
        rdChk(8'h14, 32'h0, "unmapped");
        check(resp, RESP_SLVERR, "rresp");
        axiWrite(8'h14, 32'hff);
        check(resp, RESP_SLVERR, "bresp");
        $display("reset and map test done");
        axiWrite(BAUD_ADDR, 32'h0);
        axiWrite(MASK_ADDR, 32'h3);
        axiWrite(CTRL_ADDR, 32'h80);
        rdChk(CTRL_ADDR, 32'h80, "wordLength");
        axiWrite(CTRL_ADDR, 32'h0);
        u_peer.send(8'($random(seed)), 1'b1);
        rdChk(STAT_ADDR, 32'h0, "rxDisabled");
        for (int i = 0; i < 3; i++) begin
            txOne(i == 0 ? 8'h80 : 8'($random(seed)));
            rdChk(STAT_ADDR, 32'h1, "txStat");
            rdChk(STAT_ADDR, 32'h0, "statClear");
            rdChk(CTRL_ADDR, 32'h2, "txFlag");
        end
        $display("transmit test done");
        axiWrite(CTRL_ADDR, 32'h10);
        rxOne(1'b0, 1'b1, 1'b1);
        rxOne(1'b0, 1'b1, 1'b0);
        axiWrite(CTRL_ADDR, 32'h10);
        rxOne(1'b0, 1'b0, 1'b1);
        axiWrite(CTRL_ADDR, 32'h30);
        rxOne(1'b1, 1'b0, 1'b0);
        rxOne(1'b1, 1'b1, 1'b1);
        axiWrite(CTRL_ADDR, 32'h10);
        axiWrite(MASK_ADDR, 32'h2);
        cnt = u_peer.rxCount;
        axiWrite(DATA_ADDR, 32'h5a);
        axiWrite(DATA_ADDR, 32'h33);
        waitPeer(cnt);
        check(irq, 0, "irqMasked");
        check(u_peer.rxByte, 8'h5a, "busyIgnored");
        rdChk(STAT_ADDR, 32'h1, "maskedStat");
        repeat (12 * B) @(posedge clk);
        check(u_peer.rxCount, cnt + 1, "busyNoFrame");
        $display("mask test done");
        axiWrite(MASK_ADDR, 32'h3);
        axiWrite(CTRL_ADDR, 32'h10);
        tb = 8'($random(seed));
        rb = 8'($random(seed));
        cnt = u_peer.rxCount;
        fork
            axiWrite(DATA_ADDR, {24'h0, tb});
            u_peer.send(rb, 1'b1);
        join
        waitPeer(cnt);
        check(u_peer.rxByte, tb, "duplexTx");
        rdChk(STAT_ADDR, 32'h3, "duplexStat");
        rdChk(DATA_ADDR, {24'h0, rb}, "duplexRx");
        $display("duplex test done");
        summarize();
    end
endmodule
